// >>> otp_status_pkg.sv
package otp_status_pkg;

  // register offsets of the shadowed otp map
  localparam logic [3:0] FACTORY_FIRST_ADDR = 4'h0;    // first factory register
  localparam logic [3:0] FACTORY_LAST_ADDR  = 4'h4;    // last factory register
  localparam logic [3:0] USER_FIRST_ADDR    = 4'h5;    // first user register
  localparam logic [3:0] USER_LAST_ADDR     = 4'hb;    // last user register
  localparam logic [3:0] STATUS_CHECK_ADDR  = 4'hc;    // status check register
  localparam int         SHADOW_WORDS       = 13;      // shadow words 0x00..0x0c

  // bit positions inside the user registers
  localparam int USER_LOCK_BIT      = 7;               // lock bit of first user register
  localparam int EXT_ENABLE_BIT     = 7;               // extension enable in config 6
  localparam int FREE_RUN_BIT       = 6;               // free running transmit in config 6
  localparam int CRC_FIELD_LSB      = 5;               // stored user crc lsb in config 8

  // status check bit positions
  localparam int SC_TEST_INACTIVE   = 6;
  localparam int SC_RESERVED        = 5;
  localparam int SC_USER_OK         = 4;
  localparam int SC_OFFSET_INIT     = 3;
  localparam int SC_FACTORY_OK      = 2;
  localparam int SC_OFFSET_OK       = 1;
  localparam int SC_TEMP_OK         = 0;
  localparam logic SC_RESERVED_VALUE = 1'b0;           // reserved bit constant

  // crc engine constants
  localparam logic [2:0] CRC_SEED   = 3'h7;            // seed 111
  localparam logic [2:0] CRC_POLY   = 3'h3;            // x^3+x+1 without the x^3 term

  // julian date constants
  localparam logic [6:0] YEAR_BASE  = 7'h09;           // code 0000 gives year 9

  // regulator test timing
  localparam int CLK_NS             = 10;              // 100 MHz clock period
  localparam int CAPTEST_ADLY_NS    = 20000;           // delay after free_running_transmit_enable transmit
  localparam int CAPTEST_SDLY_NS    = 20000;           // delay after sync pulse
  localparam int CAPTEST_TIME_NS    = 2000;            // regulator off duration
  localparam int CAPTEST_RATE_NS    = 100000;          // repetition period of reg tests
  localparam int ADLY_CYC           = (CAPTEST_ADLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SDLY_CYC           = (CAPTEST_SDLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIME_CYC           = (CAPTEST_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int RATE_CYC           = CAPTEST_RATE_NS / CLK_NS;

  // init phase 2 user data carried to the framer
  typedef struct packed {
    logic       extEnable;     // extension nibbles valid
    logic [3:0] directionNib;  // sensing direction nibble
    logic [3:0] revision;      // product revision
    logic [6:0] julianYear;
    logic [3:0] julianMonth;
    logic [4:0] julianDay;
  } init_data_type;

  // regulator test enables
  typedef struct packed {
    logic bufferOff;
    logic digitalOff;
    logic analogOff;
  } reg_test_type;

endpackage : otp_status_pkg

// >>> otp_crc_engine.sv
`timescale 1ns/100ps
// serial 3-bit crc over a range of shadow words, restarting each pass
module otp_crc_engine #(
  parameter int NBITS = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             enable,     // checking allowed
  input  wire logic [NBITS-1:0] dataBits,   // bits in feed order, index 0 first
  input  wire logic [2:0]       expected,   // stored crc
  output logic                  passDone,   // one-cycle end of pass
  output logic                  mismatch    // valid with passDone
);

  localparam int CW = $clog2(NBITS + 1);

  logic [CW-1:0] bitIndex;  // bit being fed
  logic [2:0]    remainder; // running remainder

  // one crc step, lsb-first stream
  function automatic logic [2:0] crc_step(input logic [2:0] r, input logic b);
    logic fb;
    fb = r[2] ^ b;
    crc_step = {r[1:0], 1'b0} ^ (fb ? otp_status_pkg::CRC_POLY : 3'h0);
  endfunction : crc_step

  // pass sequencer and remainder
  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      bitIndex  <= '0;
      remainder <= otp_status_pkg::CRC_SEED;
      passDone  <= 1'b0;
      mismatch  <= 1'b0;
    end else if (bitIndex == CW'(NBITS - 1)) begin
      // last bit: finish and restart from seed
      passDone  <= 1'b1;
      mismatch  <= crc_step(remainder, dataBits[bitIndex]) != expected;
      bitIndex  <= '0;
      remainder <= otp_status_pkg::CRC_SEED;
    end else begin
      passDone  <= 1'b0;
      mismatch  <= 1'b0;
      remainder <= crc_step(remainder, dataBits[bitIndex]);
      bitIndex  <= bitIndex + CW'(1);
    end
  end

endmodule : otp_crc_engine

// >>> otp_crc_status_monitor.sv
`timescale 1ns/100ps
module otp_crc_status_monitor (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic [7:0]                    shadowWords [13],   // shadow copy 0x00..0x0c
  input  wire logic [7:0]                    factoryCfgBits,     // factory config bits
  input  wire logic                          factoryLocked,      // factory array locked
  input  wire logic                          programExecute,     // execute programming pulse
  input  wire logic                          writeRequest,       // otp write request
  input  wire logic                          testMode,           // device in test mode
  input  wire logic                          ocPhase1Done,       // offset phase 1 timer expired
  input  wire logic                          ocPhase2Done,       // offset phase 2 timer expired
  input  wire logic                          ocFilterNormal,     // filter in normal mode
  input  wire logic                          offsetLimit,        // offset limit reached
  input  wire logic                          tempFault,          // over/under temperature
  input  wire logic                          supplyLow,          // vcc below threshold
  input  wire logic                          syncPulse,          // sync pulse detected
  input  wire logic                          transmitStart,      // framer wants to start
  input  wire logic                          transmitDone,       // response finished
  input  wire logic [3:0]                    readAddr,           // register read address
  output logic [7:0]                         readData,           // register read data
  output logic                               writeAllowed,       // otp write permitted
  output logic                               transmitEnable,     // response may run
  output logic                               transmitAbort,      // abort current response
  output logic                               freeRunning,        // free_running_transmit_enable transmit mode
  output otp_status_pkg::init_data_type      initData,           // init phase 2 fields
  output otp_status_pkg::reg_test_type       regTest             // regulator disables
);

  localparam int USER_BITS = 7 * 8 - 4;  // seven words less lock and crc
  localparam int FACT_BITS = 5 * 8 + 7;  // five words plus config less lock

  // regulator test states
  typedef enum logic [2:0] {
    BUF_IDLE  = 3'b001,
    BUF_DELAY = 3'b010,
    BUF_OFF   = 3'b100
  } buf_state_type;

  logic               userOk;         // sticky user crc flag
  logic               factoryOk;      // sticky factory crc flag
  logic               userCrcOn;      // user checking enabled
  logic               userLockSeen;   // lock sampled after reset
  logic               userPass;
  logic               userMismatch;
  logic               factPass;
  logic               factMismatch;
  logic [USER_BITS-1:0] userStream;   // user bits in feed order
  logic [FACT_BITS-1:0] factStream;   // factory bits in feed order
  logic [7:0]         statusWord;     // assembled status
  logic               slotZero;       // time slot a is zero
  logic               waitSync;       // waiting for sync after dip
  buf_state_type      bufState;
  logic [31:0]        bufCount;
  logic [31:0]        rateCount;
  logic [31:0]        offCount;
  logic               periodicOff;

  // year code to julian year
  function automatic logic [6:0] year_decode(input logic [3:0] code);
    year_decode = otp_status_pkg::YEAR_BASE + {3'h0, code};
  endfunction : year_decode

  // direction code to nibble
  function automatic logic [3:0] dir_nibble(input logic [1:0] code);
    dir_nibble = {code, 2'b00};
  endfunction : dir_nibble

  // build crc streams, lsb first, ascending addresses
  always_comb begin
    // user range minus lock and crc
    userStream = {shadowWords[11][4:0], shadowWords[10], shadowWords[9], shadowWords[8],
                  shadowWords[7], shadowWords[6], shadowWords[5][6:0]};
    factStream = {factoryCfgBits[6:0], shadowWords[4], shadowWords[3], shadowWords[2],
                  shadowWords[1], shadowWords[0]};
  end

  // user check enable: lock after reset or after programming
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      userLockSeen <= 1'b0;
      userCrcOn    <= 1'b0;
    end else begin
      userLockSeen <= 1'b1;
      // lock sampled at start or program command
      if ((!userLockSeen || programExecute) && shadowWords[5][otp_status_pkg::USER_LOCK_BIT])
        userCrcOn <= 1'b1;
    end
  end

  otp_crc_engine #(.NBITS(FACT_BITS)) factCrc (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .enable   (factoryLocked),
    .dataBits (factStream),
    .expected (factoryCfgBits[7] ? shadowWords[4][2:0] : shadowWords[4][2:0]),
    .passDone (factPass),
    .mismatch (factMismatch)
  );

  otp_crc_engine #(.NBITS(USER_BITS)) userCrc (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .enable   (userCrcOn),
    .dataBits (userStream),
    .expected (shadowWords[11][7:otp_status_pkg::CRC_FIELD_LSB]),
    .passDone (userPass),
    .mismatch (userMismatch)
  );

  // sticky error flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      userOk    <= 1'b1;
      factoryOk <= 1'b1;
    end else begin
      if (userPass && userMismatch)
        userOk <= 1'b0;
      if (factPass && factMismatch)
        factoryOk <= 1'b0;
    end
  end

  // status word assembly
  always_comb begin
    statusWord = 8'h00;
    statusWord[otp_status_pkg::SC_TEST_INACTIVE] = !testMode;
    statusWord[otp_status_pkg::SC_RESERVED]      = otp_status_pkg::SC_RESERVED_VALUE;
    statusWord[otp_status_pkg::SC_USER_OK]       = userOk;
    statusWord[otp_status_pkg::SC_OFFSET_INIT]   = ocPhase1Done && ocPhase2Done && ocFilterNormal;
    statusWord[otp_status_pkg::SC_FACTORY_OK]    = factoryOk;
    statusWord[otp_status_pkg::SC_OFFSET_OK]     = !offsetLimit;
    statusWord[otp_status_pkg::SC_TEMP_OK]       = !tempFault;
  end

  // register read port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readData <= 8'h00;
    end else if (readAddr == otp_status_pkg::STATUS_CHECK_ADDR) begin
      readData <= statusWord;
    end else if (readAddr < otp_status_pkg::STATUS_CHECK_ADDR) begin
      readData <= shadowWords[readAddr];
    end else begin
      readData <= 8'h00;
    end
  end

  assign writeAllowed = !shadowWords[5][otp_status_pkg::USER_LOCK_BIT];

  // init phase 2 data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      initData <= '0;
    end else begin
      initData.extEnable    <= shadowWords[9][otp_status_pkg::EXT_ENABLE_BIT];
      initData.directionNib <= dir_nibble(shadowWords[9][5:4]);
      initData.revision     <= shadowWords[9][3:0];
      initData.julianYear   <= year_decode(shadowWords[10][3:0]);
      initData.julianMonth  <= shadowWords[10][7:4];
      initData.julianDay    <= shadowWords[11][4:0];
    end
  end

  // free running mode when slot a is zero
  assign slotZero = (shadowWords[7] == 8'h00) && (shadowWords[6][1:0] == 2'b00);

  // free_running_transmit_enable when bit set and slot zero
  always_ff @(posedge ref_clk) begin
    if (rst)
      freeRunning <= 1'b0;
    else
      freeRunning <= shadowWords[9][otp_status_pkg::FREE_RUN_BIT] && slotZero;
  end

  // supply dip handling
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitSync <= 1'b0;
    end else if (supplyLow) begin
      waitSync <= 1'b1;
    end else if (syncPulse) begin
      waitSync <= 1'b0;
    end
  end

  assign transmitAbort  = supplyLow;
  assign transmitEnable = transmitStart && !supplyLow && !waitSync;

  // buffer regulator test sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bufState <= BUF_IDLE;
      bufCount <= 32'h0;
    end else begin
      unique case (bufState)
        BUF_IDLE: begin
          if ((freeRunning && transmitDone) || (!freeRunning && syncPulse)) begin
            bufState <= BUF_DELAY;
            bufCount <= 32'h0;
          end
        end
        BUF_DELAY: begin
          if (bufCount == 32'((freeRunning ? otp_status_pkg::ADLY_CYC : otp_status_pkg::SDLY_CYC) - 1)) begin
            bufState <= BUF_OFF;
            bufCount <= 32'h0;
          end else begin
            bufCount <= bufCount + 32'h1;
          end
        end
        BUF_OFF: begin
          if (bufCount == 32'(otp_status_pkg::TIME_CYC - 1)) begin
            bufState <= BUF_IDLE;
            bufCount <= 32'h0;
          end else begin
            bufCount <= bufCount + 32'h1;
          end
        end
      endcase
    end
  end

  // periodic digital and analog regulator test
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rateCount   <= 32'h0;
      offCount    <= 32'h0;
      periodicOff <= 1'b0;
    end else begin
      if (rateCount == 32'(otp_status_pkg::RATE_CYC - 1)) begin
        rateCount   <= 32'h0;
        periodicOff <= 1'b1;
        offCount    <= 32'h0;
      end else begin
        rateCount <= rateCount + 32'h1;
        if (periodicOff) begin
          if (offCount == 32'(otp_status_pkg::TIME_CYC - 1))
            periodicOff <= 1'b0;
          offCount <= offCount + 32'h1;
        end
      end
    end
  end

  always_comb begin
    regTest.bufferOff  = (bufState == BUF_OFF);
    regTest.digitalOff = periodicOff;
    regTest.analogOff  = periodicOff;
  end

  // user flag stays cleared after a failing pass
  property p_user_sticky;
    @(posedge ref_clk) disable iff (rst)
      !userOk |=> !userOk;
  endproperty
  a_user_sticky: assert property (p_user_sticky) else $error("user flag recovered");

  property p_fact_fail;
    @(posedge ref_clk) disable iff (rst)
      (factPass && factMismatch) |=> !statusWord[otp_status_pkg::SC_FACTORY_OK];
  endproperty
  a_fact_fail: assert property (p_fact_fail) else $error("factory flag not cleared");

  property p_bit7;
    @(posedge ref_clk) disable iff (rst)
      (readAddr == otp_status_pkg::STATUS_CHECK_ADDR) |=> !readData[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("status bit 7 set");

  property p_abort;
    @(posedge ref_clk) disable iff (rst)
      supplyLow |=> !transmitEnable until syncPulse;
  endproperty
  a_abort: assert property (p_abort) else $error("transmit before sync");

  property p_buf_len;
    @(posedge ref_clk) disable iff (rst)
      $rose(regTest.bufferOff) |-> regTest.bufferOff [*8];
  endproperty
  a_buf_len: assert property (p_buf_len) else $error("buffer test too short");

  property p_lock_write;
    @(posedge ref_clk) disable iff (rst)
      shadowWords[5][otp_status_pkg::USER_LOCK_BIT] |-> !writeAllowed;
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("write allowed when locked");

  property p_user_off;
    @(posedge ref_clk) disable iff (rst)
      !userCrcOn |-> !userPass;
  endproperty
  a_user_off: assert property (p_user_off) else $error("user crc ran disabled");

  property p_year;
    @(posedge ref_clk) disable iff (rst)
      $stable(shadowWords[10]) |=> initData.julianYear == year_decode($past(shadowWords[10][3:0]));
  endproperty
  a_year: assert property (p_year) else $error("julian year wrong");

endmodule : otp_crc_status_monitor

// >>> ecu_sync_model.sv
`timescale 1ns/100ps
// receiver side of the two-wire line: sync pulses and program command
module ecu_sync_model (
  input  wire logic ref_clk,
  output logic      syncPulse,       // one-cycle sync pulse
  output logic      programExecute   // one-cycle execute command
);
  initial begin
    syncPulse      = 1'b0;
    programExecute = 1'b0;
  end

  task automatic send_sync();
    @(negedge ref_clk);
    syncPulse = 1'b1;
    @(negedge ref_clk);
    syncPulse = 1'b0;
  endtask : send_sync

  task automatic send_program();
    @(negedge ref_clk);
    programExecute = 1'b1;
    @(negedge ref_clk);
    programExecute = 1'b0;
  endtask : send_program
endmodule : ecu_sync_model

// >>> tb_otp_crc_status_monitor.sv
`timescale 1ns/100ps
// status, init fields, crc checks and regulator tests
module tb_otp_crc_status_monitor;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] shadow [13];         // shadow words fed to the block
  logic [7:0] cfgBits = 8'h00;     // factory config bits
  logic       locked = 1'b0;
  logic       wrReq = 1'b0;
  logic [5:0] cond = 6'h00;        // {norm,p2,p1,temp,offset,test}
  logic       supplyLow = 1'b0;
  logic       txStart = 1'b0;
  logic       txDone = 1'b0;
  logic [3:0] readAddr = 4'h0;
  logic [7:0] readData, d;
  logic       syncPulse, programExecute, writeAllowed, txEn, txAbort, freeRunning;
  otp_status_pkg::init_data_type initData;
  otp_status_pkg::reg_test_type  regTest;
  int         err_total = 0;
  int         n_compared = 0;
  int         cycles = 0;
  int         n;
  logic [2:0] good;
  logic [5:0] condSet [5] = '{6'h01, 6'h02, 6'h04, 6'h18, 6'h38};  // one pattern each for test, offset, temp, two for offset init

  always #5 ref_clk = ~ref_clk;

  ecu_sync_model i_ecu_sync_model (.ref_clk(ref_clk), .syncPulse(syncPulse), .programExecute(programExecute));

  otp_crc_status_monitor i_otp_crc_status_monitor (
    .ref_clk(ref_clk), .rst(rst), .shadowWords(shadow), .factoryCfgBits(cfgBits),
    .factoryLocked(locked), .programExecute(programExecute), .writeRequest(wrReq),
    .testMode(cond[0]), .ocPhase1Done(cond[3]), .ocPhase2Done(cond[4]),
    .ocFilterNormal(cond[5]), .offsetLimit(cond[1]), .tempFault(cond[2]),
    .supplyLow(supplyLow), .syncPulse(syncPulse), .transmitStart(txStart),
    .transmitDone(txDone), .readAddr(readAddr), .readData(readData),
    .writeAllowed(writeAllowed), .transmitEnable(txEn), .transmitAbort(txAbort),
    .freeRunning(freeRunning), .initData(initData), .regTest(regTest)
  );

  // cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic waitc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : waitc

  // one read: address taken at an edge, data one cycle later
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    readAddr = a;
    @(negedge ref_clk);
    v = readData;
  endtask : rd

  task automatic do_reset(input int k);
    @(negedge ref_clk);
    rst = 1'b1;
    waitc(k);
    rst = 1'b0;
    waitc(2);
  endtask : do_reset

  // serial crc, seed 111, poly x^3+x+1, bit 0 first
  function automatic logic [2:0] crc_of(input logic [63:0] b, input int nb);
    logic [2:0] c;
    logic       fb;
    c = 3'h7;
    for (int i = 0; i < nb; i++) begin
      fb = c[2] ^ b[i];
      c = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction : crc_of

  function automatic logic [2:0] user_crc();
    return crc_of({12'h000, shadow[11][4:0], shadow[10], shadow[9], shadow[8], shadow[7], shadow[6],
                   shadow[5][6:0]}, 52);
  endfunction : user_crc

  // expected status word from the condition inputs
  function automatic logic [7:0] sc_exp(input logic uOk, input logic fOk);
    return {1'b0, ~cond[0], 1'b0, uOk, &cond[5:3], fOk, ~cond[1], ~cond[2]};
  endfunction : sc_exp

  // cycles from now until the buffer regulator test starts, then its length
  task automatic buffer_window(input int dly);
    n = 0;
    while (regTest.bufferOff !== 1'b1 && n < 3000) begin
      waitc(1);
      n++;
    end
    check("buffer delay in range", 16'h1, 16'((n >= dly - 3) && (n <= dly + 3)));
    n = 0;
    while (regTest.bufferOff === 1'b1 && n < 1000) begin
      waitc(1);
      n++;
    end
    check("buffer off length in range", 16'h1, 16'((n >= otp_status_pkg::TIME_CYC - 2) &&
                                                  (n <= otp_status_pkg::TIME_CYC + 2)));
  endtask : buffer_window

  initial begin
    for (int i = 0; i < 13; i++) shadow[i] = 8'h00;
    waitc(8);
    rst = 1'b0;
    waitc(2);
    rd(4'hc, d);
    check("status after reset", 8'h57, d);
    rd(4'hd, d);
    check("read above status", 8'h00, d);
    check("write allowed unlocked", 16'h1, 16'(writeAllowed));
    // status flags follow their conditions
    for (int k = 0; k < 5; k++) begin
      cond = condSet[k];
      waitc(3);
      rd(4'hc, d);
      check("status flags", sc_exp(1'b1, 1'b1), d);
    end
    cond = 6'h00;
    // init phase two fields, every direction code
    for (int k = 0; k < 4; k++) begin
      shadow[9]  = {k[0], 1'b0, k[1:0], 4'(k * 5)};
      shadow[10] = {4'(k * 4), 4'(k * 5)};
      shadow[11] = {3'h0, 5'(31 - k)};
      waitc(3);
      check("extension enable", 16'(k[0]), 16'(initData.extEnable));
      check("direction nibble", 16'({k[1:0], 2'b00}), 16'(initData.directionNib));
      check("revision", 16'(k * 5), 16'(initData.revision));
      check("year", 16'(9 + k * 5), 16'(initData.julianYear));
      check("month", 16'(k * 4), 16'(initData.julianMonth));
      check("day", 16'(31 - k), 16'(initData.julianDay));
    end
    // free running needs slot zero
    shadow[9] = 8'h40;
    waitc(3);
    check("free running slot zero", 16'h1, 16'(freeRunning));
    shadow[7] = 8'h01;
    waitc(3);
    check("free running slot set", 16'h0, 16'(freeRunning));
    shadow[7] = 8'h00;
    // user array check, lock then program command
    shadow[5] = 8'h80;
    shadow[6] = 8'h20;
    shadow[8] = 8'h5a;
    shadow[10] = 8'h3c;
    shadow[11] = 8'h07;
    good = user_crc();
    shadow[11][7:5] = good;
    waitc(2);
    check("write blocked by lock", 16'h0, 16'(writeAllowed));
    i_ecu_sync_model.send_program();
    waitc(130);
    rd(4'hc, d);
    check("user crc good", sc_exp(1'b1, 1'b1), d);
    shadow[11][5] = ~shadow[11][5];
    waitc(130);
    rd(4'hc, d);
    check("user crc bad", sc_exp(1'b0, 1'b1), d);
    shadow[11][5] = ~shadow[11][5];
    waitc(130);
    rd(4'hc, d);
    check("user flag sticky", sc_exp(1'b0, 1'b1), d);
    do_reset(2);
    rd(4'hc, d);
    check("user flag after reset", sc_exp(1'b1, 1'b1), d);
    shadow[8] = 8'h5b;
    waitc(130);
    rd(4'hc, d);
    check("user crc enabled at reset", sc_exp(1'b0, 1'b1), d);
    // factory array: only checked while locked
    shadow[0] = 8'h11;
    cfgBits = 8'h85;
    for (int v = 0; v < 8; v++) begin
      shadow[4][2:0] = 3'(v);
      if (crc_of({17'h0, cfgBits[6:0], shadow[4], shadow[3], shadow[2], shadow[1], shadow[0]}, 47) != 3'(v)) break;
    end
    waitc(120);
    rd(4'hc, d);
    check("factory unlocked", sc_exp(1'b0, 1'b1), d);
    locked = 1'b1;
    waitc(120);
    rd(4'hc, d);
    check("factory crc bad", sc_exp(1'b0, 1'b0), d);
    // supply dip aborts and waits for sync
    shadow[9] = 8'h00;
    txStart = 1'b1;
    supplyLow = 1'b1;
    waitc(1);
    check("abort on dip", 16'h1, 16'(txAbort));
    check("no transmit on dip", 16'h0, 16'(txEn));
    supplyLow = 1'b0;
    waitc(3);
    check("wait for sync", 16'h0, 16'(txEn));
    waitc(2500);
    i_ecu_sync_model.send_sync();
    waitc(1);
    check("resume after sync", 16'h1, 16'(txEn));
    buffer_window(otp_status_pkg::SDLY_CYC - 2);
    // free running: test after each transmission
    shadow[9] = 8'h40;
    waitc(3);
    txDone = 1'b1;
    waitc(1);
    txDone = 1'b0;
    buffer_window(otp_status_pkg::ADLY_CYC - 1);
    // periodic regulator tests: length and repetition
    n = 0;
    while (regTest.digitalOff !== 1'b1 && n < 20000) begin
      waitc(1);
      n++;
    end
    check("periodic test seen", 16'h1, 16'(n < 20000));
    check("analog off with digital", 16'h1, 16'(regTest.analogOff));
    waitc(otp_status_pkg::TIME_CYC - 1);
    check("periodic off held", 16'h3, 16'({regTest.digitalOff, regTest.analogOff}));
    waitc(1);
    check("periodic off ended", 16'h0, 16'({regTest.digitalOff, regTest.analogOff}));
    n = 0;
    while (regTest.digitalOff !== 1'b1 && n < 20000) begin
      waitc(1);
      n++;
    end
    check("periodic repeat gap", 16'(otp_status_pkg::RATE_CYC - otp_status_pkg::TIME_CYC), 16'(n));
    wrReq = 1'b1;
    conclude();
  end
endmodule : tb_otp_crc_status_monitor
